// file: dv/frame_mode_control_test.sv
// Purpose: self-checking bench for frame counting, readout and power mode selection
// Assumes: host model owns the serial pins; bench owns results, pins and reset
// Notes: corner frames first, then random frame lengths with a fixed seed
`timescale 1ns/1ps
module frame_mode_control_test;
  import adc_ctrl_pkg::*;
  `define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
  logic sys_clk = 1'b0; // 100 ns clock
  logic reset_n = 1'b0; // active-low reset
  logic start = 1'b0; // frame request to the host model
  logic [5:0] n_edges = 6'h00; // serial edges in the next frame
  logic pair = 1'b0; // channel pair level
  logic ref_pin = 1'b0; // reference source level
  logic [RES_W-1:0] res_a = '0; // converter a result
  logic [RES_W-1:0] res_b = '0; // converter b result
  logic frame_n, sclk, a_out, a_oe_n, b_out, b_oe_n, conv, pwr_up, ext_ref, int_ref;
  logic done, oe_end, pwr_seen, rel_seen;
  logic [31:0] seen_a, seen_b;
  power_mode_t mode;
  power_mode_t exp_mode = MODE_NORMAL; // mode the bench predicts
  int n_fail = 0;
  int checks_done = 0;
  int n_start = 0; // conversion start pulses seen
  int starts_before;
  logic [5:0] corner [12] = '{6'h01, 6'h05, 6'h01, 6'h05, 6'h05, 6'h0c,
                              6'h20, 6'h10, 6'h28, 6'h09, 6'h0a, 6'h02};
  always #50 sys_clk = ~sys_clk;
  frame_mode_control dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .serial_clk(sclk), .frame_select_n(frame_n),
    .channel_pair_select(pair), .reference_source_pin(ref_pin),
    .result_a(res_a), .result_b(res_b),
    .result_line_a_out(a_out), .result_line_a_oe_n(a_oe_n),
    .result_line_b_out(b_out), .result_line_b_oe_n(b_oe_n),
    .conversion_start(conv), .power_mode(mode), .powering_up(pwr_up),
    .use_external_ref(ext_ref), .internal_ref_enable(int_ref));
  host_port_model host (
    .start(start), .n_edges(n_edges), .a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out),
    .b_oe_n(b_oe_n), .powering_up(pwr_up), .frame_select_n(frame_n), .serial_clk(sclk),
    .done(done), .seen_a(seen_a), .seen_b(seen_b), .oe_end(oe_end), .pwr_seen(pwr_seen),
    .rel_seen(rel_seen));
  // count conversion start pulses, one per frame fall expected
  always @(negedge sys_clk) begin
    if (conv === 1'b1) begin
      n_start++;
    end
  end
  // word as it leaves the line: pad, id, pair, result msb first, pad
  function automatic logic [15:0] word(input logic id, input logic [RES_W-1:0] r);
    return {LEAD_BIT, id, pair, r, LEAD_BIT};
  endfunction
  // mode after a frame that ended with n falling edges
  function automatic power_mode_t next_mode(input power_mode_t m, input int n);
    if (n < 2) begin
      return m;
    end
    if (n >= 10) begin
      return MODE_NORMAL;
    end
    return (m == MODE_NORMAL) ? MODE_PARTIAL : MODE_FULL;
  endfunction
  // run one frame of n edges with fresh results, then check everything it touched
  task automatic frame(input logic [5:0] n, input int t);
    int k;
    @(posedge sys_clk);
    res_a <= RES_W'($urandom);
    res_b <= RES_W'($urandom);
    pair <= 1'($urandom);
    n_edges <= n;
    @(posedge sys_clk);
    starts_before = n_start;
    start <= 1'b1;
    // let the model clear done from the previous frame before polling it
    @(posedge sys_clk);
    for (k = 0; k < 60 && done !== 1'b1; k++) begin
      @(posedge sys_clk);
    end
    if (k == 60) begin
      n_fail++;
      results();
    end
    start <= 1'b0;
    `CHK("start pulses", 1, n_start - starts_before)
    `CHK("powering up", exp_mode != MODE_NORMAL, pwr_seen)
    `CHK("released at rise", 1'b1, rel_seen)
    if (n > 0) begin
      `CHK("oe after last edge", n >= EDGE_DUAL, oe_end)
    end
    if (n == EDGE_WORD) begin
      `CHK("single word a", word(STATUS_ID_A, res_a), seen_a[15:0])
      `CHK("single word b", word(STATUS_ID_B, res_b), seen_b[15:0])
    end
    if (n >= EDGE_DUAL) begin
      `CHK("line a", {word(STATUS_ID_A, res_a), word(STATUS_ID_B, res_b)}, seen_a)
      `CHK("line b", {word(STATUS_ID_B, res_b), 16'h0000}, seen_b)
    end
    exp_mode = next_mode(exp_mode, n);
    `CHK("power mode", exp_mode, mode)
    $display("test %0d edges %0d done", t, n);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog sized well beyond the longest run of frames
  initial begin
    #400000;
    n_fail++;
    results();
  end
  initial begin
    void'($urandom(48169));
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK("mode after reset", MODE_NORMAL, mode)
    // reference source follows the pin both ways
    for (int v = 0; v < 4; v++) begin
      ref_pin <= v[0];
      repeat (5) @(posedge sys_clk);
      `CHK("external ref", v[0], ext_ref)
      `CHK("internal ref", ~v[0], int_ref)
    end
    foreach (corner[i]) begin
      frame(corner[i], i);
    end
    for (int t = 0; t < 20; t++) begin
      frame(6'($urandom_range(40)), t + 12);
    end
    results();
  end
endmodule

// file: dv/host_port_model.sv
// Purpose: host serial port model that frames, clocks and reads the result lines
// Assumes: serial clock of 6 ns runs only inside a frame, stands still low otherwise
// Notes: a released line reads back as the inverse of its last bit, never as a fresh value
`timescale 1ns/1ps
module host_port_model (
  // request from the bench
  input wire logic start,
  input wire logic [5:0] n_edges,
  // lines from the device
  input wire logic a_out,
  input wire logic a_oe_n,
  input wire logic b_out,
  input wire logic b_oe_n,
  input wire logic powering_up,
  // serial port pins
  output logic frame_select_n,
  output logic serial_clk,
  // what the host saw
  output logic done,
  output logic [31:0] seen_a,
  output logic [31:0] seen_b,
  output logic oe_end,
  output logic pwr_seen,
  output logic rel_seen
);
  initial begin
    frame_select_n = 1'b1;
    serial_clk = 1'b0;
    done = 1'b0;
  end
  // one frame per start: fall, n falling edges, long low tail, rise, quiet gap
  always @(posedge start) begin
    done = 1'b0;
    seen_a = '0;
    seen_b = '0;
    frame_select_n = 1'b0;
    #2;
    for (int i = 1; i <= n_edges; i++) begin
      // sample the bit standing since the previous falling edge; a dual read
      // holds 32 bits, so edges past it only clock the device, not the capture
      if (i <= 32) begin
        seen_a = {seen_a[30:0], a_oe_n ? ~seen_a[0] : a_out};
        seen_b = {seen_b[30:0], b_oe_n ? ~seen_b[0] : b_out};
      end
      #1 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
      #2;
    end
    oe_end = a_oe_n;
    // low tail keeps the frame visible to the slow mode logic
    #600 pwr_seen = powering_up;
    frame_select_n = 1'b1;
    #1 rel_seen = a_oe_n & b_oe_n;
    // quiet interval before the bench may start again
    #600 done = 1'b1;
  end
endmodule

// file: rtl/adc_ctrl_pkg.sv
// Purpose: shared constants and types for the dual converter frame and mode control
// Assumes: serial clock edges are counted from the falling edge of the frame select
// Notes: edge thresholds are counts of serial clock falling edges within one frame
package adc_ctrl_pkg;
  // serial clock falling-edge thresholds
  localparam int CNT_W = 6;                    // wide enough to hold the dual-read count
  localparam logic [5:0] EDGE_GLITCH = 6'h02;  // below this a frame end changes nothing
  localparam logic [5:0] EDGE_KEEP = 6'h0a;    // at or past this the device stays powered
  localparam logic [5:0] EDGE_WORD = 6'h10;    // one complete conversion word
  localparam logic [5:0] EDGE_DUAL = 6'h20;    // both words read, line released
  localparam logic [5:0] EDGE_ZERO = 6'h00;    // counter value at frame start
  localparam logic [5:0] EDGE_ONE = 6'h01;     // counter increment
  // result word layout
  localparam int RES_W = 12;                   // converter result width
  localparam int WORD_W = 16;                  // bits shifted per converter
  localparam logic [3:0] WORD_LAST = 4'hf;     // index of first bit sent
  localparam logic STATUS_ID_A = 1'b0;         // status bit naming converter a
  localparam logic STATUS_ID_B = 1'b1;         // status bit naming converter b
  localparam logic LEAD_BIT = 1'b0;            // leading and trailing pad bits
  // power modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PARTIAL = 2'b01,
    MODE_FULL = 2'b10
  } power_mode_t;
endpackage

// file: rtl/bit_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: input is a slowly changing level from another domain or a pin
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // level in and out
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg; // first stage, read only by the second
  logic sync_reg; // second stage
  logic meta_next;
  logic sync_next;

  // next values are plain shifts
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // register both stages
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// file: rtl/frame_mode_control.sv
// Purpose: frame counting, result shifting, line release and power mode selection
// Assumes: serial clock runs only inside frames; result words are stable while a frame is low
// Notes: link logic runs on serial clock falling edges, mode logic on sys_clk
// Functional notes
// - sample and start conversion on frame fall
// - rise between edges ten and sixteen: abandon, powered
// - full conversion needs sixteen serial clocks
// - keep driving line after sixteen edges
// - second sixteen clocks shift other converter's result
// - status bits name converter before each result
// - release line at edge thirty-two or rise
// - three power modes chosen by frame end
// - reference pin low: on-chip reference used
// - reference pin high: external reference overrides
// - rise between edges two and ten: partial
// - rise before edge two keeps present mode
// - partial plus early rise gives full power-down
// - power-up starts at fall, completes past ten
`timescale 1ns/1ps
module frame_mode_control (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // serial port from the host
  input wire logic serial_clk,
  input wire logic frame_select_n,
  // static pins
  input wire logic channel_pair_select,
  input wire logic reference_source_pin,
  // converter core results
  input wire logic [adc_ctrl_pkg::RES_W-1:0] result_a,
  input wire logic [adc_ctrl_pkg::RES_W-1:0] result_b,
  // result lines
  output logic result_line_a_out,
  output logic result_line_a_oe_n,
  output logic result_line_b_out,
  output logic result_line_b_oe_n,
  // power and conversion control
  output logic conversion_start,
  output adc_ctrl_pkg::power_mode_t power_mode,
  output logic powering_up,
  output logic use_external_ref,
  output logic internal_ref_enable
);
  import adc_ctrl_pkg::*;

  // ---------------- link domain: serial clock falling edges ----------------
  logic [CNT_W-1:0] edge_cnt_reg;  // falling edges seen in this frame
  logic [CNT_W-1:0] edge_cnt_next;
  logic line_a_reg;                // bit presented on line a
  logic line_a_next;
  logic line_b_reg;                // bit presented on line b
  logic line_b_next;
  logic pair_reg;                  // channel pair reported in status
  logic pair_next;
  logic [CNT_W-1:0] end_count_reg; // edge count caught at frame rise
  logic [WORD_W-1:0] word_a;       // framed result of converter a
  logic [WORD_W-1:0] word_b;       // framed result of converter b

  // frame one converter result behind its pad and status bits
  function automatic logic [WORD_W-1:0] frame_word(input logic id, input logic pair,
                                                    input logic [RES_W-1:0] res);
    frame_word = {LEAD_BIT, id, pair, res, LEAD_BIT};
  endfunction

  // pick the bit shown after a given edge count
  function automatic logic pick_bit(input logic [WORD_W-1:0] w, input logic [CNT_W-1:0] n);
    logic [3:0] idx;
    idx = WORD_LAST - n[3:0];
    pick_bit = w[idx];
  endfunction

  assign word_a = frame_word(STATUS_ID_A, pair_reg, result_a);
  assign word_b = frame_word(STATUS_ID_B, pair_reg, result_b);

  // count edges, saturating once the dual read is done
  always_comb begin
    if (edge_cnt_reg == EDGE_DUAL) begin
      edge_cnt_next = EDGE_DUAL;
    end else begin
      edge_cnt_next = edge_cnt_reg + EDGE_ONE;
    end
    // the pair pin is caught on the first edge; it is a status echo only
    pair_next = (edge_cnt_reg == EDGE_ZERO) ? channel_pair_select : pair_reg;
    if (edge_cnt_next < EDGE_WORD) begin
      line_a_next = pick_bit(word_a, edge_cnt_next);
      line_b_next = pick_bit(word_b, edge_cnt_next);
    end else begin
      // line a keeps driving with the other converter's word
      line_a_next = pick_bit(word_b, edge_cnt_next);
      line_b_next = LEAD_BIT;
    end
  end

  // frame high holds the link logic cleared, so every frame restarts at zero
  always_ff @(negedge serial_clk or posedge frame_select_n) begin
    if (frame_select_n) begin
      edge_cnt_reg <= EDGE_ZERO;
      line_a_reg <= LEAD_BIT;
      line_b_reg <= LEAD_BIT;
      pair_reg <= 1'b0;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
      line_a_reg <= line_a_next;
      line_b_reg <= line_b_next;
      pair_reg <= pair_next;
    end
  end

  // catch the count at the frame's own rising edge; it stays put until the next
  // rise, long after sys_clk has read it, so the word crosses safely
  always_ff @(posedge frame_select_n) begin
    end_count_reg <= edge_cnt_reg;
  end

  // release on frame rise or when the dual read completes
  assign result_line_a_oe_n = frame_select_n | (edge_cnt_reg == EDGE_DUAL);
  assign result_line_b_oe_n = frame_select_n | (edge_cnt_reg == EDGE_DUAL);
  assign result_line_a_out = line_a_reg;
  assign result_line_b_out = line_b_reg;

  // ---------------- system domain: mode control ----------------
  logic frame_n_sync;       // frame select seen on sys_clk
  logic ref_sync;           // reference select seen on sys_clk
  logic frame_n_prev_reg;   // previous frame level for edge finding
  logic frame_n_prev_next;
  logic start_reg;          // conversion start pulse
  logic start_next;
  power_mode_t mode_reg;    // present power mode
  power_mode_t mode_next;
  logic ref_ext_reg;        // external reference chosen
  logic ref_ext_next;
  logic frame_fall;
  logic frame_rise;

  bit_sync #(.RESET_VAL(1'b1)) u_frame_sync (
    .clk(sys_clk),
    .reset_n(reset_n),
    .async_in(frame_select_n),
    .sync_out(frame_n_sync)
  );

  bit_sync #(.RESET_VAL(1'b0)) u_ref_sync (
    .clk(sys_clk),
    .reset_n(reset_n),
    .async_in(reference_source_pin),
    .sync_out(ref_sync)
  );

  assign frame_fall = frame_n_prev_reg & ~frame_n_sync;
  assign frame_rise = ~frame_n_prev_reg & frame_n_sync;

  // decide the mode from where the frame ended
  always_comb begin
    frame_n_prev_next = frame_n_sync;
    start_next = frame_fall;
    ref_ext_next = ref_sync;
    mode_next = mode_reg;
    if (frame_rise) begin
      if (end_count_reg < EDGE_GLITCH) begin
        mode_next = mode_reg;
      end else if (end_count_reg < EDGE_KEEP) begin
        case (mode_reg)
          MODE_NORMAL: mode_next = MODE_PARTIAL;
          MODE_PARTIAL: mode_next = MODE_FULL;
          MODE_FULL: mode_next = MODE_FULL;
          default: mode_next = MODE_NORMAL;
        endcase
      end else begin
        mode_next = MODE_NORMAL;
      end
    end
  end

  // register mode state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_n_prev_reg <= 1'b1;
      start_reg <= 1'b0;
      mode_reg <= MODE_NORMAL;
      ref_ext_reg <= 1'b0;
    end else begin
      frame_n_prev_reg <= frame_n_prev_next;
      start_reg <= start_next;
      mode_reg <= mode_next;
      ref_ext_reg <= ref_ext_next;
    end
  end

  assign conversion_start = start_reg;
  assign power_mode = mode_reg;
  // a frame opened in a power-down mode is the power-up attempt
  assign powering_up = (mode_reg != MODE_NORMAL) & ~frame_n_prev_reg;
  assign use_external_ref = ref_ext_reg;
  assign internal_ref_enable = ~ref_ext_reg;

  // ---------------- checks ----------------
  sequence s_rise_early;
    frame_rise && end_count_reg >= EDGE_GLITCH && end_count_reg < EDGE_KEEP;
  endsequence

  property p_start_on_fall;
    @(posedge sys_clk) disable iff (!reset_n)
      frame_fall |=> conversion_start ##1 !conversion_start;
  endproperty
  a_start_on_fall: assert property (p_start_on_fall) else $error("no start pulse");

  property p_mode_only_at_rise;
    @(posedge sys_clk) disable iff (!reset_n)
      !frame_rise |=> $stable(power_mode);
  endproperty
  a_mode_only_at_rise: assert property (p_mode_only_at_rise) else $error("mode moved");

  property p_glitch_keeps;
    @(posedge sys_clk) disable iff (!reset_n)
      frame_rise && end_count_reg < EDGE_GLITCH |=> $stable(power_mode);
  endproperty
  a_glitch_keeps: assert property (p_glitch_keeps) else $error("glitch changed mode");

  property p_enter_partial;
    @(posedge sys_clk) disable iff (!reset_n)
      s_rise_early and power_mode == MODE_NORMAL |=> power_mode == MODE_PARTIAL;
  endproperty
  a_enter_partial: assert property (p_enter_partial) else $error("no partial");

  property p_enter_full;
    @(posedge sys_clk) disable iff (!reset_n)
      s_rise_early and power_mode == MODE_PARTIAL |=> power_mode == MODE_FULL;
  endproperty
  a_enter_full: assert property (p_enter_full) else $error("no full");

  property p_stay_up;
    @(posedge sys_clk) disable iff (!reset_n)
      frame_rise && end_count_reg >= EDGE_KEEP |=> power_mode == MODE_NORMAL;
  endproperty
  a_stay_up: assert property (p_stay_up) else $error("not powered");

  property p_release_dual;
    @(negedge serial_clk) disable iff (frame_select_n)
      edge_cnt_reg == EDGE_DUAL |-> result_line_a_oe_n && result_line_b_oe_n;
  endproperty
  a_release_dual: assert property (p_release_dual) else $error("line held");

  property p_keep_driving;
    @(negedge serial_clk) disable iff (frame_select_n)
      edge_cnt_reg >= EDGE_WORD && edge_cnt_reg < EDGE_DUAL |-> !result_line_a_oe_n;
  endproperty
  a_keep_driving: assert property (p_keep_driving) else $error("line released early");

  property p_status_b;
    @(negedge serial_clk) disable iff (frame_select_n)
      edge_cnt_reg == (EDGE_WORD + EDGE_ONE) |-> result_line_a_out == STATUS_ID_B;
  endproperty
  a_status_b: assert property (p_status_b) else $error("bad status bit");

  property p_ref_follow;
    @(posedge sys_clk) disable iff (!reset_n)
      use_external_ref |-> !internal_ref_enable;
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("both references");
endmodule
